// >>> common/stkg_map.svh
// register offsets, field positions, reset values and timing figures of the
// sidetone and keyclick control bank.
// assumes inclusion by bare name from the design modules, the checker and the bench.
`ifndef STKG_MAP_SVH
`define STKG_MAP_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define STKG_ADDR_W 6
`define STKG_ADDR_MIXER 6'h03
`define STKG_ADDR_AUDIO2 6'h04

// ----------------------------------------------------------------------------
// mixer_gain_control fields
// ----------------------------------------------------------------------------
`define STKG_MUTE_BIT 15
`define STKG_GAIN_MSB 14
`define STKG_GAIN_LSB 8
`define STKG_MICROPHONE_SELECT_MSB 7
`define STKG_MICROPHONE_SELECT_LSB 5
`define STKG_MICROPHONE_TO_CONVERTER_BIT 4
`define STKG_CELLPHONE_TO_CONVERTER_BIT 3
`define STKG_STFLAG_BIT 0

// ----------------------------------------------------------------------------
// audio_control_two fields
// ----------------------------------------------------------------------------
`define STKG_CLKEN_BIT 15
`define STKG_AMP_MSB 14
`define STKG_AMP_LSB 12
`define STKG_RATE_BIT 11
`define STKG_FREQ_MSB 10
`define STKG_FREQ_LSB 8
`define STKG_LEN_MSB 7
`define STKG_LEN_LSB 4
`define STKG_LFLAG_BIT 3
`define STKG_RFLAG_BIT 2

// ----------------------------------------------------------------------------
// reset values and gain codes
// ----------------------------------------------------------------------------
`define STKG_RST_MUTE 1'b1
`define STKG_RST_GAIN 7'h45
`define STKG_RST_MICROPHONE_SELECT 3'h0
`define STKG_RST_AMP 3'h4
`define STKG_RST_FREQ 3'h4
`define STKG_RST_LEN 4'h1
`define STKG_RST_APPLIED 7'h00
`define STKG_GAIN_ZERO_DB 7'h45
`define STKG_GAIN_MAX 7'h5d

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define STKG_CLK_HZ 50000000
// lowest keyclick tone, in millihertz
`define STKG_CLICK_BASE_MHZ 62500
`define STKG_HALF_CNT_W 19

`endif

// >>> common/stkg_pkg.sv
// types shared by the sidetone and keyclick control bank.
// assumes stkg_map.svh is on the include path.
`default_nettype none
package stkg_pkg;
  typedef logic [6:0] stkg_gain_t;

  typedef enum logic [2:0] {
    CLICK_IDLE = 3'b001,
    CLICK_HIGH = 3'b010,
    CLICK_LOW = 3'b100
  } stkg_click_e;
endpackage
`default_nettype wire

// >>> common/stkg_ramp_if.sv
// target and applied gain of one soft-stepped gain stage.
// assumes the control module drives target and step, the ramp the rest.
`timescale 1ns/100ps
`default_nettype none
interface stkg_ramp_if;
  import stkg_pkg::*;
  stkg_gain_t target;
  logic stepTick;
  stkg_gain_t applied;
  logic settled;

  modport ctrl (output target, output stepTick, input applied, input settled);
  modport ramp (input target, input stepTick, output applied, output settled);
endinterface
`default_nettype wire

// >>> hdl/stkg_ramp.sv
// soft-step ramp: applied gain moves one 0.5 dB code per step toward target.
// assumes stepTick is a one-cycle pulse synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
`include "stkg_map.svh"
module stkg_ramp import stkg_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  stkg_ramp_if.ramp port
);
  stkg_gain_t applied;
  stkg_gain_t next_applied;

  always_comb begin
    next_applied = applied;
    if (port.stepTick) begin
      if (applied < port.target) begin
        next_applied = applied + 7'h01;
      end else if (applied > port.target) begin
        next_applied = applied - 7'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      applied <= `STKG_RST_APPLIED;
    end else begin
      applied <= next_applied;
    end
  end

  assign port.applied = applied;
  // flag follows the comparison so a new target drops it at once
  assign port.settled = (applied == port.target);
endmodule
`default_nettype wire

// >>> hdl/stkg_ctrl.sv
// control registers for sidetone gain and mute, cell-phone routing,
// keyclick tone generation and gain soft-step flags.
// assumes all inputs synchronous to clk; wordClkTick pulses once per word clock.
`timescale 1ns/100ps
`default_nettype none
`include "stkg_map.svh"

// Operation
// R1 - sidetone mute bit mutes the sidetone path; resets to one
// R2 - gain code 0 is -34.5 dB, 0.5 dB steps, codes 93 up give 12 dB
// R3 - cell-phone routing bit connects that input to the converter; resets zero
// R4 - sidetone settled flag reads one when applied gain equals programmed gain
// R5 - click enable starts a keyclick and clears itself after programmed length
// R6 - click amplitude field selects level monotonically, medium at reset
// R7 - input gain step rate: one step per one or two word clocks
// R8 - with AGC on, step rate bit is read-only noise threshold flag
// R9 - click frequency doubles per code from 62.5 Hz to 8 kHz
// R10 - click length gives two to thirty-two tone periods in steps of two
// R11 - left playback settled flag reads one when left gain reaches target
// R12 - right playback settled flag reads one when right gain reaches target
// R13 - microphone select and routing fields are plain storage resetting zero
// R14 - new sidetone gain ramps in 0.5 dB steps, flag low until reached
module stkg_ctrl import stkg_pkg::*; #(
  parameter int CLICK_BASE_HALF = int'((64'(`STKG_CLK_HZ) * 64'd1000) / (64'd2 * 64'(`STKG_CLICK_BASE_MHZ)))
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`STKG_ADDR_W-1:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  output logic [15:0] regRdData,
  input wire logic wordClkTick,
  input wire logic agcHeadsetOn,
  input wire logic agcHandsetOn,
  input wire logic noiseBelowThreshold,
  input wire logic [6:0] dacLeftTarget,
  input wire logic [6:0] dacRightTarget,
  input wire logic dacStepTwo,
  output logic sidetoneMute,
  output logic [6:0] sidetoneGainApplied,
  output logic signed [7:0] sidetoneGainHalfDb,
  output logic cellphoneToConverter,
  output logic [2:0] microphoneSelect,
  output logic microphoneToConverter,
  output logic inputGainStepRate,
  output logic inputGainStepTick,
  output logic [6:0] dacLeftGainApplied,
  output logic [6:0] dacRightGainApplied,
  output logic clickTone,
  output logic clickActive,
  output logic [2:0] clickAmplitude
);
  localparam int HW = `STKG_HALF_CNT_W;
  localparam logic [HW-1:0] BASE_HALF = CLICK_BASE_HALF[HW-1:0];

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  function automatic logic regHit(input logic [`STKG_ADDR_W-1:0] addr,
                                  input logic [`STKG_ADDR_W-1:0] offset);
    regHit = (addr == offset);
  endfunction

  logic wrMixer;
  logic wrAudio2;
  assign wrMixer = regWrite && regHit(regAddr, `STKG_ADDR_MIXER);
  assign wrAudio2 = regWrite && regHit(regAddr, `STKG_ADDR_AUDIO2);

  // --------------------------------------------------------------------------
  // register fields
  // --------------------------------------------------------------------------
  stkg_gain_t sidetoneGain;
  stkg_gain_t next_sidetoneGain;
  logic next_sidetoneMute;
  logic next_cellphoneToConverter;
  logic [2:0] next_microphoneSelect;
  logic next_microphoneToConverter;
  logic clickEnable;
  logic next_clickEnable;
  logic [2:0] next_clickAmplitude;
  logic next_inputGainStepRate;
  logic [2:0] clickFrequency;
  logic [2:0] next_clickFrequency;
  logic [3:0] clickLength;
  logic [3:0] next_clickLength;
  logic clickDone;
  logic agcActive;

  assign agcActive = agcHeadsetOn || agcHandsetOn;

  always_comb begin
    next_sidetoneMute = sidetoneMute;
    next_sidetoneGain = sidetoneGain;
    next_microphoneSelect = microphoneSelect;
    next_microphoneToConverter = microphoneToConverter;
    next_cellphoneToConverter = cellphoneToConverter;
    next_clickEnable = clickEnable;
    next_clickAmplitude = clickAmplitude;
    next_inputGainStepRate = inputGainStepRate;
    next_clickFrequency = clickFrequency;
    next_clickLength = clickLength;
    // R5 self-clearing enable
    if (clickDone) begin
      next_clickEnable = 1'b0;
    end
    if (wrMixer) begin
      // R1 mute control
      next_sidetoneMute = regWrData[`STKG_MUTE_BIT];
      next_sidetoneGain = regWrData[`STKG_GAIN_MSB:`STKG_GAIN_LSB];
      // R13 plain storage
      next_microphoneSelect = regWrData[`STKG_MICROPHONE_SELECT_MSB:`STKG_MICROPHONE_SELECT_LSB];
      next_microphoneToConverter = regWrData[`STKG_MICROPHONE_TO_CONVERTER_BIT];
      // R3 routing control
      next_cellphoneToConverter = regWrData[`STKG_CELLPHONE_TO_CONVERTER_BIT];
    end
    if (wrAudio2) begin
      // a write of one in the completion cycle wins and starts a new click
      next_clickEnable = regWrData[`STKG_CLKEN_BIT];
      // R6 amplitude select
      next_clickAmplitude = regWrData[`STKG_AMP_MSB:`STKG_AMP_LSB];
      // R8 write ignored under agc
      if (!agcActive) begin
        next_inputGainStepRate = regWrData[`STKG_RATE_BIT];
      end
      next_clickFrequency = regWrData[`STKG_FREQ_MSB:`STKG_FREQ_LSB];
      next_clickLength = regWrData[`STKG_LEN_MSB:`STKG_LEN_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sidetoneMute <= `STKG_RST_MUTE;
      sidetoneGain <= `STKG_RST_GAIN;
      microphoneSelect <= `STKG_RST_MICROPHONE_SELECT;
      microphoneToConverter <= 1'b0;
      cellphoneToConverter <= 1'b0;
      clickEnable <= 1'b0;
      clickAmplitude <= `STKG_RST_AMP;
      inputGainStepRate <= 1'b0;
      clickFrequency <= `STKG_RST_FREQ;
      clickLength <= `STKG_RST_LEN;
    end else begin
      sidetoneMute <= next_sidetoneMute;
      sidetoneGain <= next_sidetoneGain;
      microphoneSelect <= next_microphoneSelect;
      microphoneToConverter <= next_microphoneToConverter;
      cellphoneToConverter <= next_cellphoneToConverter;
      clickEnable <= next_clickEnable;
      clickAmplitude <= next_clickAmplitude;
      inputGainStepRate <= next_inputGainStepRate;
      clickFrequency <= next_clickFrequency;
      clickLength <= next_clickLength;
    end
  end

  // --------------------------------------------------------------------------
  // word clock divider
  // --------------------------------------------------------------------------
  logic wordPhase;
  logic next_wordPhase;
  logic tickHalfRate;

  always_comb begin
    next_wordPhase = wordPhase;
    if (wordClkTick) begin
      next_wordPhase = !wordPhase;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wordPhase <= 1'b0;
    end else begin
      wordPhase <= next_wordPhase;
    end
  end

  assign tickHalfRate = wordClkTick && wordPhase;
  // R7 step every one or two word clocks
  assign inputGainStepTick = inputGainStepRate ? tickHalfRate : wordClkTick;

  // --------------------------------------------------------------------------
  // soft-step ramps: sidetone, playback left, playback right
  // --------------------------------------------------------------------------
  stkg_gain_t rampTarget [3];
  logic rampTick [3];
  stkg_gain_t rampApplied [3];
  logic rampSettled [3];

  // R14 sidetone ramps one code per word clock
  assign rampTarget[0] = sidetoneGain;
  assign rampTick[0] = wordClkTick;
  assign rampTarget[1] = dacLeftTarget;
  assign rampTick[1] = dacStepTwo ? tickHalfRate : wordClkTick;
  assign rampTarget[2] = dacRightTarget;
  assign rampTick[2] = dacStepTwo ? tickHalfRate : wordClkTick;

  generate
    for (genvar g = 0; g < 3; g++) begin : gRamp
      stkg_ramp_if rif ();
      assign rif.target = rampTarget[g];
      assign rif.stepTick = rampTick[g];
      assign rampApplied[g] = rif.applied;
      assign rampSettled[g] = rif.settled;
      stkg_ramp uRamp (
        .clk(clk),
        .rst_n(rst_n),
        .port(rif.ramp)
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // applied gain outputs
  // --------------------------------------------------------------------------
  logic signed [7:0] next_sidetoneGainHalfDb;
  stkg_gain_t clampedGain;

  always_comb begin
    // R2 codes above the top all give 12 dB
    clampedGain = (rampApplied[0] > `STKG_GAIN_MAX) ? `STKG_GAIN_MAX : rampApplied[0];
    next_sidetoneGainHalfDb = $signed({1'b0, clampedGain}) - $signed({1'b0, `STKG_GAIN_ZERO_DB});
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sidetoneGainHalfDb <= 8'sh00;
      sidetoneGainApplied <= `STKG_RST_APPLIED;
      dacLeftGainApplied <= `STKG_RST_APPLIED;
      dacRightGainApplied <= `STKG_RST_APPLIED;
    end else begin
      sidetoneGainHalfDb <= next_sidetoneGainHalfDb;
      sidetoneGainApplied <= clampedGain;
      dacLeftGainApplied <= rampApplied[1];
      dacRightGainApplied <= rampApplied[2];
    end
  end

  // --------------------------------------------------------------------------
  // keyclick tone generator
  // --------------------------------------------------------------------------
  stkg_click_e clickState;
  stkg_click_e next_clickState;
  logic [HW-1:0] halfCnt;
  logic [HW-1:0] next_halfCnt;
  logic [4:0] periodCnt;
  logic [4:0] next_periodCnt;
  logic [HW-1:0] halfLast;
  logic [4:0] periodLast;
  logic halfEnd;

  // R9 half period halves per frequency code
  assign halfLast = (BASE_HALF >> clickFrequency) - {{(HW-1){1'b0}}, 1'b1};
  // R10 last period index is twice the code plus one
  assign periodLast = {clickLength, 1'b1};
  assign halfEnd = (halfCnt == halfLast);

  always_comb begin
    next_clickState = clickState;
    next_halfCnt = halfCnt;
    next_periodCnt = periodCnt;
    clickDone = 1'b0;
    case (clickState)
      CLICK_IDLE: begin
        next_halfCnt = '0;
        next_periodCnt = 5'h00;
        // R5 enable starts a click
        if (clickEnable) begin
          next_clickState = CLICK_HIGH;
        end
      end
      CLICK_HIGH: begin
        next_halfCnt = halfCnt + {{(HW-1){1'b0}}, 1'b1};
        if (halfEnd) begin
          next_halfCnt = '0;
          next_clickState = CLICK_LOW;
        end
      end
      CLICK_LOW: begin
        next_halfCnt = halfCnt + {{(HW-1){1'b0}}, 1'b1};
        if (halfEnd) begin
          next_halfCnt = '0;
          // R10 count whole periods
          if (periodCnt == periodLast) begin
            clickDone = 1'b1;
            next_clickState = CLICK_IDLE;
          end else begin
            next_periodCnt = periodCnt + 5'h01;
            next_clickState = CLICK_HIGH;
          end
        end
      end
      default: begin
        next_clickState = CLICK_IDLE;
      end
    endcase
    // software clearing the enable aborts a click in progress
    if (!clickEnable && clickState != CLICK_IDLE) begin
      next_clickState = CLICK_IDLE;
      clickDone = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clickState <= CLICK_IDLE;
      halfCnt <= '0;
      periodCnt <= 5'h00;
    end else begin
      clickState <= next_clickState;
      halfCnt <= next_halfCnt;
      periodCnt <= next_periodCnt;
    end
  end

  assign clickTone = (clickState == CLICK_HIGH);
  assign clickActive = (clickState != CLICK_IDLE);

  // --------------------------------------------------------------------------
  // read-back
  // --------------------------------------------------------------------------
  logic [15:0] next_regRdData;

  always_comb begin
    next_regRdData = 16'h0000;
    if (regHit(regAddr, `STKG_ADDR_MIXER)) begin
      next_regRdData[`STKG_MUTE_BIT] = sidetoneMute;
      next_regRdData[`STKG_GAIN_MSB:`STKG_GAIN_LSB] = sidetoneGain;
      next_regRdData[`STKG_MICROPHONE_SELECT_MSB:`STKG_MICROPHONE_SELECT_LSB] = microphoneSelect;
      next_regRdData[`STKG_MICROPHONE_TO_CONVERTER_BIT] = microphoneToConverter;
      next_regRdData[`STKG_CELLPHONE_TO_CONVERTER_BIT] = cellphoneToConverter;
      // R4 sidetone settled flag
      next_regRdData[`STKG_STFLAG_BIT] = rampSettled[0];
    end else if (regHit(regAddr, `STKG_ADDR_AUDIO2)) begin
      next_regRdData[`STKG_CLKEN_BIT] = clickEnable;
      next_regRdData[`STKG_AMP_MSB:`STKG_AMP_LSB] = clickAmplitude;
      // R8 noise flag replaces the rate bit under agc
      next_regRdData[`STKG_RATE_BIT] = agcActive ? noiseBelowThreshold : inputGainStepRate;
      next_regRdData[`STKG_FREQ_MSB:`STKG_FREQ_LSB] = clickFrequency;
      next_regRdData[`STKG_LEN_MSB:`STKG_LEN_LSB] = clickLength;
      // R11 left settled flag
      next_regRdData[`STKG_LFLAG_BIT] = rampSettled[1];
      // R12 right settled flag
      next_regRdData[`STKG_RFLAG_BIT] = rampSettled[2];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdData <= 16'h0000;
    end else begin
      regRdData <= next_regRdData;
    end
  end
endmodule
`default_nettype wire

// >>> verification/stkg_ctrl_sva.sv
// port assertions for the sidetone and keyclick control bank.
// assumes it is bound onto stkg_ctrl and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
`include "stkg_map.svh"
module stkg_ctrl_sva import stkg_pkg::*; #(
  parameter int CLICK_BASE_HALF = 400000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`STKG_ADDR_W-1:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic wordClkTick,
  input wire logic agcHeadsetOn,
  input wire logic agcHandsetOn,
  input wire logic sidetoneMute,
  input wire logic [6:0] sidetoneGainApplied,
  input wire logic signed [7:0] sidetoneGainHalfDb,
  input wire logic cellphoneToConverter,
  input wire logic [2:0] microphoneSelect,
  input wire logic microphoneToConverter,
  input wire logic inputGainStepRate,
  input wire logic inputGainStepTick,
  input wire logic clickTone,
  input wire logic clickActive,
  input wire logic [2:0] clickAmplitude
);
  // ------
  // helpers
  // ------
  logic wrMix;
  logic wrAud;
  logic signed [7:0] expHalf;
  logic [2:0] freqSeen;
  int hiCnt;
  assign wrMix = regWrite && regAddr == `STKG_ADDR_MIXER;
  assign wrAud = regWrite && regAddr == `STKG_ADDR_AUDIO2;
  // frequency as last written, and length of the current high half
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      freqSeen <= `STKG_RST_FREQ;
      hiCnt <= 0;
    end else begin
      if (wrAud) begin
        freqSeen <= regWrData[`STKG_FREQ_MSB:`STKG_FREQ_LSB];
      end
      hiCnt <= clickTone ? hiCnt + 1 : 0;
    end
  end
  // every code from the top one up gives the same gain
  assign expHalf = sidetoneGainApplied >= `STKG_GAIN_MAX ? 8'sd24 : $signed({1'b0, sidetoneGainApplied}) - 8'sd69;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence click_launch;
    wrAud && regWrData[`STKG_CLKEN_BIT] && !clickActive;
  endsequence
  sequence click_sounding;
    ##1 (clickActive && clickTone);
  endsequence

  // ------
  // checks
  // ------
  mute_follow_a:
  assert property (wrMix |=> sidetoneMute == $past(regWrData[`STKG_MUTE_BIT]))
  else $error("sidetone mute not taken from write");
  route_follow_a:
  assert property (wrMix |=> cellphoneToConverter == $past(regWrData[`STKG_CELLPHONE_TO_CONVERTER_BIT]))
  else $error("cell-phone routing not taken from write");
  mic_store_a:
  assert property (wrMix |=> {microphoneSelect, microphoneToConverter} == $past(regWrData[7:4]))
  else $error("microphone fields not stored");
  amp_store_a:
  assert property (wrAud |=> clickAmplitude == $past(regWrData[`STKG_AMP_MSB:`STKG_AMP_LSB]))
  else $error("click amplitude not stored");
  rate_locked_a:
  assert property (wrAud && (agcHeadsetOn || agcHandsetOn) |=> $stable(inputGainStepRate))
  else $error("step rate written while agc on");
  step_every_a:
  assert property (wordClkTick && !inputGainStepRate |-> inputGainStepTick)
  else $error("step missing at full rate");
  step_source_a:
  assert property (inputGainStepTick |-> wordClkTick)
  else $error("step without word clock");
  gain_step_a:
  assert property ($changed(sidetoneGainApplied) |-> 7'(sidetoneGainApplied - $past(sidetoneGainApplied)) inside {7'h01, 7'h7f})
  else $error("sidetone gain jumped more than one code");
  half_db_a:
  assert property ($stable(sidetoneGainApplied) [*3] |-> sidetoneGainHalfDb == expHalf)
  else $error("sidetone gain in half dB wrong");
  click_start_a:
  assert property (click_launch |=> click_sounding)
  else $error("keyclick did not start");
  tone_half_a:
  assert property ($fell(clickTone) && clickActive |-> hiCnt == (CLICK_BASE_HALF >> freqSeen))
  else $error("keyclick high half has wrong length");
endmodule

bind stkg_ctrl stkg_ctrl_sva #(.CLICK_BASE_HALF(CLICK_BASE_HALF)) u_sva (
  .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
  .wordClkTick(wordClkTick), .agcHeadsetOn(agcHeadsetOn), .agcHandsetOn(agcHandsetOn),
  .sidetoneMute(sidetoneMute), .sidetoneGainApplied(sidetoneGainApplied),
  .sidetoneGainHalfDb(sidetoneGainHalfDb), .cellphoneToConverter(cellphoneToConverter),
  .microphoneSelect(microphoneSelect), .microphoneToConverter(microphoneToConverter),
  .inputGainStepRate(inputGainStepRate), .inputGainStepTick(inputGainStepTick),
  .clickTone(clickTone), .clickActive(clickActive), .clickAmplitude(clickAmplitude)
);
`default_nettype wire

// >>> verification/stkg_ctrl_tb.sv
// self-checking bench for the sidetone and keyclick control bank.
// assumes the checker is bound in and a short click base count.
`timescale 1ns/100ps
`default_nettype none
`include "stkg_map.svh"
module stkg_ctrl_tb import stkg_pkg::*;;
  localparam int HALF = 256;
  localparam logic [5:0] MIX = `STKG_ADDR_MIXER;
  localparam logic [5:0] AUD = `STKG_ADDR_AUDIO2;
  logic clk = 0, rst_n = 0, regWrite = 0, wordClkTick = 0, dacStepTwo = 1;
  logic agcHeadsetOn = 0, agcHandsetOn = 0, noiseBelowThreshold = 0, rdWant = 0;
  logic [5:0] regAddr = '0;
  logic [15:0] regWrData = '0, regRdData;
  logic [31:0] ent;
  logic [31:0] rdQ[$];
  stkg_gain_t dacLeftTarget = '0, dacRightTarget = '0, sidetoneGainApplied, dacLeftGainApplied;
  stkg_gain_t dacRightGainApplied;
  logic signed [7:0] sidetoneGainHalfDb;
  logic sidetoneMute, cellphoneToConverter, microphoneToConverter, inputGainStepRate;
  logic inputGainStepTick, clickTone, clickActive;
  logic [2:0] microphoneSelect, clickAmplitude;
  int mismatches = 0, nCompared = 0;

  always #10 clk = ~clk;

  stkg_ctrl #(.CLICK_BASE_HALF(HALF)) u_dut (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRdData(regRdData), .wordClkTick(wordClkTick), .agcHeadsetOn(agcHeadsetOn),
    .agcHandsetOn(agcHandsetOn), .noiseBelowThreshold(noiseBelowThreshold),
    .dacLeftTarget(dacLeftTarget), .dacRightTarget(dacRightTarget), .dacStepTwo(dacStepTwo),
    .sidetoneMute(sidetoneMute), .sidetoneGainApplied(sidetoneGainApplied),
    .sidetoneGainHalfDb(sidetoneGainHalfDb), .cellphoneToConverter(cellphoneToConverter),
    .microphoneSelect(microphoneSelect), .microphoneToConverter(microphoneToConverter),
    .inputGainStepRate(inputGainStepRate), .inputGainStepTick(inputGainStepTick),
    .dacLeftGainApplied(dacLeftGainApplied), .dacRightGainApplied(dacRightGainApplied),
    .clickTone(clickTone), .clickActive(clickActive), .clickAmplitude(clickAmplitude)
  );

  // ------
  // tasks
  // ------
  task automatic conclude();
    if (mismatches == 0 && nCompared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m = 16'hffff);
    nCompared++;
    if ((got & m) !== (exp & m)) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // strobe is held one cycle and then followed by an idle cycle so back-to-back writes never collide
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    regAddr = a;
    regWrData = d;
    regWrite = 1;
    step();
    regWrite = 0;
    step();
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] e, input logic [15:0] m);
    regAddr = a;
    step();
    rdQ.push_back({m, e});
    rdWant = 1;
    step();
  endtask

  task automatic tick();
    wordClkTick = 1;
    step();
    wordClkTick = 0;
    step(2);
  endtask

  // read data is one cycle behind the address
  always @(posedge clk) begin
    #2;
    if (rdWant) begin
      rdWant = 0;
      ent = rdQ.pop_front();
      cmp(regRdData, ent[15:0], ent[31:16]);
    end
  end

  // ------
  // scenarios
  // ------
  initial begin
    int g, l, f, n, d, rises;
    logic t;
    logic [15:0] v;
    g = $urandom(32'h5a3c);
    step(5);
    rst_n = 1;
    rd(MIX, 16'hc500, 16'hffff);
    rd(AUD, 16'h4410, 16'hfff3);
    rd(6'h05, 16'h0000, 16'hffff);
    cmp(16'({sidetoneMute, cellphoneToConverter, clickAmplitude}), 16'h14);
    repeat (4) begin
      v = 16'($urandom);
      wr(MIX, v);
      rd(MIX, v & 16'hfff8, 16'hfffe);
      cmp(16'({sidetoneMute, microphoneSelect, microphoneToConverter, cellphoneToConverter}), 16'({v[15], v[7:3]}));
    end
    g = $urandom_range(2, 92);
    wr(MIX, {1'b0, 7'(g), 8'h08});
    repeat (g - 1) tick();
    rd(MIX, 16'h0000, 16'h0001);
    tick();
    rd(MIX, {1'b0, 7'(g), 8'h09}, 16'hffff);
    cmp(16'(sidetoneGainHalfDb), 16'(g - 69));
    wr(MIX, 16'h7f08);
    repeat (127 - g) tick();
    rd(MIX, 16'h7f09, 16'hffff);
    cmp(16'({sidetoneGainHalfDb, 1'b0, sidetoneGainApplied}), 16'h185d);
    l = $urandom_range(2, 20);
    dacLeftTarget = 7'(l);
    step();
    rd(AUD, 16'h0004, 16'h000c);
    repeat (2 * l - 2) tick();
    cmp(16'(dacLeftGainApplied), 16'(l - 1));
    rd(AUD, 16'h0004, 16'h000c);
    repeat (2) tick();
    rd(AUD, 16'h000c, 16'h000c);
    dacStepTwo = 0;
    dacRightTarget = 7'h03;
    step();
    rd(AUD, 16'h0008, 16'h000c);
    repeat (3) tick();
    cmp(16'(dacRightGainApplied), 16'h3);
    rd(AUD, 16'h000c, 16'h000c);
    wr(AUD, 16'h0800);
    n = 0;
    repeat (4) begin
      wordClkTick = 1;
      #1 n += int'(inputGainStepTick);
      step();
      wordClkTick = 0;
      step();
    end
    cmp(16'(n), 16'h2);
    for (f = 0; f < 2; f++) begin
      agcHeadsetOn = (f == 0);
      agcHandsetOn = (f == 1);
      noiseBelowThreshold = 0;
      wr(AUD, 16'h0000);
      cmp(16'(inputGainStepRate), 16'h1);
      rd(AUD, 16'h0000, 16'h0800);
      noiseBelowThreshold = 1;
      rd(AUD, 16'h0800, 16'h0800);
    end
    agcHandsetOn = 0;
    wr(AUD, 16'h0000);
    cmp(16'(inputGainStepRate), 16'h0);
    for (f = 0; f < 8; f++) begin
      l = (f == 7) ? 15 : $urandom_range(0, 3);
      v = {1'b1, 3'(f), 1'b0, 3'(f), 4'(l), 4'h0};
      wr(AUD, v);
      cmp(16'(clickAmplitude), 16'(f));
      // the click is already sounding here, so its first cycle is counted
      d = 0;
      rises = 0;
      t = 0;
      while (clickActive === 1'b1 && d < 20000) begin
        rises += int'(clickTone && !t);
        t = clickTone;
        d++;
        step();
      end
      if (d >= 20000) begin
        mismatches++;
        conclude();
      end
      cmp(16'(d), 16'(4 * (l + 1) * (HALF >> f)));
      cmp(16'(rises), 16'(2 * (l + 1)));
      rd(AUD, v & 16'h7ff0, 16'hfff0);
    end
    // aborting mid-click must stop the tone at once
    wr(AUD, 16'hc4f0);
    step(3);
    wr(AUD, 16'h44f0);
    cmp(16'({clickActive, clickTone}), 16'h0);
    conclude();
  end
endmodule
`default_nettype wire
